// ===== include/baboe_pkg.sv
// shared types and constants of the byte alu and bit operation datapath
// assumes one clock domain shared with the decoder and the file register store
package baboe_pkg;

	// datapath widths
	localparam int unsigned DATA_W = 8; // byte datapath
	localparam int unsigned FADDR_W = 7; // file address, locations 0 to 127
	localparam int unsigned BIT_IDX_W = 3; // bit index 0 to 7
	localparam int unsigned BUS_ADDR_W = 4; // register port address
	localparam int unsigned BUS_DATA_W = 32; // register port data

	// register port offsets, one aligned word each
	localparam logic [3:0] REG_ACC_OFF = 4'h0; // working accumulator
	localparam logic [3:0] REG_STATUS_OFF = 4'h4; // carry, digit carry, zero
	localparam logic [3:0] REG_CTRL_OFF = 4'h8; // execution enable
	localparam logic [3:0] REG_STATE_OFF = 4'hc; // busy and skip pending, read only

	// field positions
	localparam int unsigned STATUS_C_BIT = 0;
	localparam int unsigned STATUS_DC_BIT = 1;
	localparam int unsigned STATUS_Z_BIT = 2;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned STATE_BUSY_BIT = 0;
	localparam int unsigned STATE_SKIP_BIT = 1;

	// values after reset
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [7:0] ZERO_BYTE = 8'h00; // cleared file register value
	localparam logic [31:0] BUS_IDLE = 32'h0000_0000; // read data between reads

	// operations this datapath executes
	typedef enum logic [2:0] {
		add_literal_op,
		and_literal_op,
		add_file_op,
		and_file_op,
		bit_clear_op,
		bit_set_op,
		skip_if_bit_set_op,
		clear_file_op
	} baboe_op_type;

	// one decoded instruction from the decoder
	typedef struct packed {
		baboe_op_type op; // operation
		logic [7:0] literal; // immediate for literal operations
		logic [6:0] file_addr; // addressed file register
		logic dest_file; // 0 accumulator, 1 file register
		logic [2:0] bit_idx; // selected bit
	} baboe_req_type;

	// status flags
	typedef struct packed {
		logic zero;
		logic digit_carry_flag;
		logic carry;
	} baboe_flags_type;

	localparam baboe_flags_type FLAGS_RST = '{zero: 1'b0, digit_carry_flag: 1'b0, carry: 1'b0};

endpackage : baboe_pkg

// ===== src/baboe_adder.sv
// byte adder with carry out of the top bit and of bit 3
// assumes purely combinational use; the caller registers the results
`timescale 1ns/100ps

module baboe_adder #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic [WIDTH-1:0] a_in,
	input wire logic [WIDTH-1:0] b_in,
	output logic [WIDTH-1:0] sum_out,
	output logic carry_out,
	output logic digit_carry_out
);

	// the digit carry taps bit 3, so narrower words make no sense
	generate
		if (WIDTH < 8 || (WIDTH % 4) != 0) begin : g_bad_width
			$error("baboe_adder: width must be a multiple of 4, at least 8");
		end
	endgenerate

	logic [WIDTH:0] full_sum; // sum with carry out of the top bit
	logic [4:0] low_sum; // low nibble sum with carry out of bit 3

	// add once for the whole word, once for the low nibble
	always_comb begin
		full_sum = {1'b0, a_in} + {1'b0, b_in};
		low_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
		sum_out = full_sum[WIDTH-1:0];
		carry_out = full_sum[WIDTH];
		digit_carry_out = low_sum[4];
	end

endmodule : baboe_adder

// ===== src/baboe_exec.sv
// execution datapath: literal and file add/and, bit clear/set, bit test skip, file clear
// assumes decoder and file register store share ref_clk_in and srst_in;
// file store returns read data the cycle after file_re_out, with port pin levels beside it
//
// Contract
// - add literal to accumulator, update c dc z
// - and literal into accumulator, update z only
// - and file with accumulator, to destination, z
// - add file to accumulator, to destination, c dc z
// - destination bit: 0 accumulator, 1 file
// - file operand is 7-bit address 0..127
// - bit clear zeroes one bit, no flags
// - bit set raises one bit, no flags
// - set test bit: discard next, run nop
// - clear test bit: next runs, no flags
// - file clear writes zero, sets zero flag
// - port registers use pin levels as source
// - true conditional test takes two cycles; here the test takes three cycles and the discarded next op one more
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

module baboe_exec (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// decoder side
	input wire logic req_valid_in,
	input wire baboe_pkg::baboe_req_type req_in,
	output logic req_ready_out,
	output logic done_out,
	output logic squashed_out,
	output logic skip_out,
	// file register store side
	output logic [6:0] file_addr_out,
	output logic file_re_out,
	input wire logic [7:0] file_rdata_in,
	input wire logic file_is_port_in,
	input wire logic [7:0] file_pin_data_in,
	output logic file_we_out,
	output logic [7:0] file_wdata_out,
	// architectural state
	output logic [7:0] acc_out,
	output baboe_pkg::baboe_flags_type flags_out,
	// register port
	input wire logic [3:0] bus_addr_in,
	input wire logic [31:0] bus_wdata_in,
	input wire logic bus_we_in,
	input wire logic bus_re_in,
	output logic [31:0] bus_rdata_out
);

	// one-hot mask of the selected bit
	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction : bit_mask

	// true when a byte is all zeros
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == baboe_pkg::ZERO_BYTE);
	endfunction : is_zero

	// low byte of the register port write data
	function automatic logic [7:0] bus_wr_data_byte(input logic [31:0] d);
		bus_wr_data_byte = d[7:0];
	endfunction : bus_wr_data_byte

	typedef enum logic [1:0] {
		st_idle,
		st_read,
		st_exec
	} baboe_state_type;

	baboe_state_type state_r; // sequencer state
	baboe_pkg::baboe_req_type req_r; // instruction in flight
	logic [7:0] acc_r; // working accumulator
	baboe_pkg::baboe_flags_type flags_r; // status flags
	logic ctrl_en_r; // software execution enable
	logic skip_pend_r; // next accepted instruction runs as nop
	logic ready_r; // decoder may issue
	logic done_r; // instruction retired
	logic squashed_r; // retired instruction was discarded
	logic skip_r; // test was true this instruction
	logic [6:0] faddr_r; // file address to the store
	logic fre_r; // file read strobe
	logic fwe_r; // file write strobe
	logic [7:0] fwdata_r; // file write data
	logic [31:0] rdata_r; // register port read data

	logic accept; // instruction taken this cycle
	logic is_literal; // operation uses the immediate
	logic [7:0] file_opnd; // source byte from the file store
	logic [7:0] opnd_b; // second alu operand
	logic [7:0] add_sum; // adder result
	logic add_c; // carry out of bit 7
	logic add_dc; // carry out of bit 3
	logic [7:0] result; // byte produced by the operation
	logic wr_acc; // result goes to the accumulator
	logic wr_file; // result goes to the file register
	logic upd_z; // zero flag changes
	logic upd_cdc; // carry and digit carry change
	logic new_z; // new zero flag value
	logic test_true; // tested bit is one
	logic bus_wr_acc; // software writes the accumulator
	logic bus_wr_status; // software writes the flags
	logic bus_wr_ctrl; // software writes the enable

	assign accept = ce_in && req_valid_in && ready_r && (state_r == st_idle);
	assign is_literal = (req_r.op == baboe_pkg::add_literal_op) ||
		(req_r.op == baboe_pkg::and_literal_op);
	assign bus_wr_acc = ce_in && bus_we_in && (bus_addr_in == baboe_pkg::REG_ACC_OFF);
	assign bus_wr_status = ce_in && bus_we_in && (bus_addr_in == baboe_pkg::REG_STATUS_OFF);
	assign bus_wr_ctrl = ce_in && bus_we_in && (bus_addr_in == baboe_pkg::REG_CTRL_OFF);

	// port registers feed back what the pins show, not the output latch
	assign file_opnd = file_is_port_in ? file_pin_data_in : file_rdata_in;
	assign opnd_b = is_literal ? req_r.literal : file_opnd;

	// shared adder for both add operations
	baboe_adder #(
		.WIDTH(baboe_pkg::DATA_W)
	) u_adder (
		.a_in(acc_r),
		.b_in(opnd_b),
		.sum_out(add_sum),
		.carry_out(add_c),
		.digit_carry_out(add_dc)
	);

	// operation decode in the execute cycle
	always_comb begin
		result = add_sum;
		wr_acc = 1'b0;
		wr_file = 1'b0;
		upd_z = 1'b0;
		upd_cdc = 1'b0;
		test_true = file_opnd[req_r.bit_idx];
		case (req_r.op)
			baboe_pkg::add_literal_op: begin
				result = add_sum;
				wr_acc = 1'b1;
				upd_z = 1'b1;
				upd_cdc = 1'b1;
			end
			baboe_pkg::and_literal_op: begin
				result = acc_r & req_r.literal;
				wr_acc = 1'b1;
				upd_z = 1'b1;
			end
			baboe_pkg::add_file_op: begin
				result = add_sum;
				wr_acc = !req_r.dest_file;
				wr_file = req_r.dest_file;
				upd_z = 1'b1;
				upd_cdc = 1'b1;
			end
			baboe_pkg::and_file_op: begin
				result = acc_r & file_opnd;
				wr_acc = !req_r.dest_file;
				wr_file = req_r.dest_file;
				upd_z = 1'b1;
			end
			baboe_pkg::bit_clear_op: begin
				result = file_opnd & ~bit_mask(req_r.bit_idx);
				wr_file = 1'b1;
			end
			baboe_pkg::bit_set_op: begin
				result = file_opnd | bit_mask(req_r.bit_idx);
				wr_file = 1'b1;
			end
			baboe_pkg::skip_if_bit_set_op: begin
				// a test writes nothing and leaves every flag alone
				result = file_opnd;
			end
			baboe_pkg::clear_file_op: begin
				result = baboe_pkg::ZERO_BYTE;
				wr_file = 1'b1;
				upd_z = 1'b1;
			end
			default: begin
				result = add_sum;
			end
		endcase
		new_z = is_zero(result);
	end

	// sequencer: idle, optional file read, execute
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			state_r <= st_idle;
			ready_r <= 1'b0;
		end else if (ce_in) begin
			case (state_r)
				st_idle: begin
					if (accept && skip_pend_r) begin
						// discarded instruction retires now as the nop cycle
						ready_r <= ctrl_en_r;
					end else if (accept) begin
						ready_r <= 1'b0;
						// literal ops and file clear need no source byte
						if (req_in.op == baboe_pkg::add_literal_op ||
							req_in.op == baboe_pkg::and_literal_op ||
							req_in.op == baboe_pkg::clear_file_op) begin
							state_r <= st_exec;
						end else begin
							state_r <= st_read;
						end
					end else begin
						// enable changes only gate new issue, never one in flight
						ready_r <= ctrl_en_r;
					end
				end
				st_read: begin
					state_r <= st_exec;
				end
				st_exec: begin
					state_r <= st_idle;
					ready_r <= ctrl_en_r;
				end
				default: begin
					state_r <= st_idle;
					ready_r <= 1'b0;
				end
			endcase
		end
	end

	// latch the instruction and address the file store
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			req_r <= '0;
			faddr_r <= 7'h00;
			fre_r <= 1'b0;
		end else if (ce_in) begin
			fre_r <= 1'b0;
			if (accept && !skip_pend_r) begin
				req_r <= req_in;
				faddr_r <= req_in.file_addr;
				// read strobe only where a source byte is needed
				fre_r <= !(req_in.op == baboe_pkg::add_literal_op ||
					req_in.op == baboe_pkg::and_literal_op ||
					req_in.op == baboe_pkg::clear_file_op);
			end
		end
	end

	// file write and retire strobes, one cycle each
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			fwe_r <= 1'b0;
			fwdata_r <= baboe_pkg::ZERO_BYTE;
			done_r <= 1'b0;
			squashed_r <= 1'b0;
			skip_r <= 1'b0;
		end else if (ce_in) begin
			fwe_r <= 1'b0;
			done_r <= 1'b0;
			squashed_r <= 1'b0;
			skip_r <= 1'b0;
			if (state_r == st_exec) begin
				fwe_r <= wr_file;
				fwdata_r <= result;
				done_r <= 1'b1;
				skip_r <= (req_r.op == baboe_pkg::skip_if_bit_set_op) && test_true;
			end else if (accept && skip_pend_r) begin
				done_r <= 1'b1;
				squashed_r <= 1'b1;
			end
		end
	end

	// skip pending: armed by a true test, spent on the next issued instruction
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			skip_pend_r <= 1'b0;
		end else if (ce_in) begin
			if (state_r == st_exec && req_r.op == baboe_pkg::skip_if_bit_set_op) begin
				skip_pend_r <= test_true;
			end else if (accept) begin
				skip_pend_r <= 1'b0;
			end
		end
	end

	// accumulator; a retiring instruction wins over a software write
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			acc_r <= baboe_pkg::ACC_RST;
		end else if (ce_in) begin
			if (state_r == st_exec && wr_acc) begin
				acc_r <= result;
			end else if (bus_wr_acc) begin
				acc_r <= bus_wr_data_byte(bus_wdata_in);
			end
		end
	end

	// flags; hardware updates win so no event is lost to a software write
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			flags_r <= baboe_pkg::FLAGS_RST;
		end else if (ce_in) begin
			if (state_r == st_exec && (upd_z || upd_cdc)) begin
				if (upd_z) begin
					flags_r.zero <= new_z;
				end
				if (upd_cdc) begin
					flags_r.carry <= add_c;
					flags_r.digit_carry_flag <= add_dc;
				end
			end else if (bus_wr_status) begin
				flags_r.carry <= bus_wdata_in[baboe_pkg::STATUS_C_BIT];
				flags_r.digit_carry_flag <= bus_wdata_in[baboe_pkg::STATUS_DC_BIT];
				flags_r.zero <= bus_wdata_in[baboe_pkg::STATUS_Z_BIT];
			end
		end
	end

	// execution enable written by software
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			ctrl_en_r <= baboe_pkg::CTRL_EN_RST;
		end else if (bus_wr_ctrl) begin
			ctrl_en_r <= bus_wdata_in[baboe_pkg::CTRL_EN_BIT];
		end
	end

	// register port read data, valid only in the cycle after the strobe
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			rdata_r <= baboe_pkg::BUS_IDLE;
		end else if (ce_in) begin
			rdata_r <= baboe_pkg::BUS_IDLE;
			if (bus_re_in) begin
				case (bus_addr_in)
					baboe_pkg::REG_ACC_OFF: begin
						rdata_r <= {24'h00_0000, acc_r};
					end
					baboe_pkg::REG_STATUS_OFF: begin
						rdata_r <= {29'h0000_0000, flags_r.zero,
							flags_r.digit_carry_flag, flags_r.carry};
					end
					baboe_pkg::REG_CTRL_OFF: begin
						rdata_r <= {31'h0000_0000, ctrl_en_r};
					end
					baboe_pkg::REG_STATE_OFF: begin
						rdata_r <= {30'h0000_0000, skip_pend_r, (state_r != st_idle)};
					end
					default: begin
						// unmapped offsets read as zero
						rdata_r <= baboe_pkg::BUS_IDLE;
					end
				endcase
			end
		end
	end

	// every output straight from a flip-flop
	assign req_ready_out = ready_r;
	assign done_out = done_r;
	assign squashed_out = squashed_r;
	assign skip_out = skip_r;
	assign file_addr_out = faddr_r;
	assign file_re_out = fre_r;
	assign file_we_out = fwe_r;
	assign file_wdata_out = fwdata_r;
	assign acc_out = acc_r;
	assign flags_out = flags_r;
	assign bus_rdata_out = rdata_r;

endmodule : baboe_exec

// ===== testbench/baboe_exec_chk.sv
// checker for the execution datapath, watching only its top ports
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/100ps

module baboe_exec_chk (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic req_valid_in,
	input wire baboe_pkg::baboe_req_type req_in,
	input wire logic req_ready_out,
	input wire logic done_out,
	input wire logic squashed_out,
	input wire logic skip_out,
	input wire logic file_re_out,
	input wire logic file_we_out,
	input wire logic [7:0] file_wdata_out,
	input wire logic [7:0] acc_out,
	input wire baboe_pkg::baboe_flags_type flags_out,
	input wire logic bus_we_in
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (srst_in);

	logic take; // request accepted at this edge
	assign take = req_valid_in && req_ready_out && ce_in;

	// an armed skip may turn any accepted op into a one-cycle nop
	sequence s_lit;
		take && (req_in.op == baboe_pkg::add_literal_op || req_in.op == baboe_pkg::and_literal_op);
	endsequence
	sequence s_clr;
		take && req_in.op == baboe_pkg::clear_file_op;
	endsequence
	sequence s_skip_take;
		skip_out ##1 (take && !squashed_out);
	endsequence

	property p_lit;
		s_lit |=> squashed_out or (!done_out ##1 (done_out && !file_we_out && !file_re_out));
	endproperty
	property p_clr;
		s_clr |=> squashed_out or
			(!done_out ##1 (done_out && file_we_out && file_wdata_out == 8'h00 && flags_out.zero));
	endproperty
	property p_re_done;
		file_re_out |-> !req_ready_out ##1 (!req_ready_out && !done_out) ##1 done_out;
	endproperty
	property p_we;
		file_we_out |-> done_out && !squashed_out && !skip_out;
	endproperty
	property p_skip;
		skip_out |-> done_out && !file_we_out && !squashed_out && $stable(flags_out);
	endproperty
	property p_squash;
		squashed_out |-> done_out && !file_we_out && $stable(flags_out) && $stable(acc_out);
	endproperty
	property p_nop;
		s_skip_take |=> done_out && squashed_out;
	endproperty
	property p_flags;
		$changed(flags_out) |-> done_out || $past(bus_we_in);
	endproperty

	a_lit: assert property (p_lit) else $error("literal op timing wrong");
	a_clr: assert property (p_clr) else $error("file clear wrong");
	a_re_done: assert property (p_re_done) else $error("file op timing wrong");
	a_we: assert property (p_we) else $error("stray file write");
	a_skip: assert property (p_skip) else $error("bit test changed state");
	a_squash: assert property (p_squash) else $error("discarded op had effect");
	a_nop: assert property (p_nop) else $error("op after true test not discarded");
	a_flags: assert property (p_flags) else $error("flags changed off retire");
endmodule : baboe_exec_chk

bind baboe_exec baboe_exec_chk baboe_exec_chk_inst (.*);

// ===== testbench/baboe_fs_model.sv
// file register store model facing the execution datapath
// assumes reads are answered in the cycle after the read strobe
`timescale 1ns/100ps

module baboe_fs_model (
	input wire logic ref_clk_in,
	input wire logic [6:0] addr_in,
	input wire logic re_in,
	input wire logic we_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	output logic is_port_out,
	output logic [7:0] pin_out
);
	localparam logic [6:0] PORT_ADDR = 7'h20; // the one port location
	logic [7:0] mem [128]; // locations 0 to 127, preloaded by the bench
	logic [7:0] pins_r = 8'hff; // pin levels of the port

	// data stands one cycle only; otherwise it flips so stale use shows
	always @(posedge ref_clk_in) begin
		rdata_out <= re_in ? mem[addr_in] : ~rdata_out;
		is_port_out <= re_in ? (addr_in == PORT_ADDR) : 1'b0;
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
	end
	assign pin_out = pins_r;
endmodule : baboe_fs_model

// ===== testbench/testbench.sv
// self-checking bench for the execution datapath with a file store model
// assumes the store model answers reads one cycle after the strobe
`timescale 1ns/100ps

module testbench;
	logic ref_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic ce_in = 1'b1; // kept on: no frozen-cycle scenario fits
	logic req_valid_in = 1'b0;
	baboe_pkg::baboe_req_type req_in = '0;
	logic [3:0] bus_addr_in = 4'h0;
	logic [31:0] bus_wdata_in = 32'h0;
	logic bus_we_in = 1'b0;
	logic bus_re_in = 1'b0;
	logic req_ready_out, done_out, squashed_out, skip_out, file_re_out, file_we_out;
	logic file_is_port_in, wev, skp, sqh;
	logic [6:0] file_addr_out;
	logic [7:0] file_rdata_in, file_pin_data_in, file_wdata_out, acc_out, wdv;
	logic [31:0] bus_rdata_out;
	baboe_pkg::baboe_flags_type flags_out;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	int lat;

	always #12.5 ref_clk_in = ~ref_clk_in;

	baboe_exec baboe_exec_inst (.*);
	baboe_fs_model baboe_fs_model_inst (.ref_clk_in(ref_clk_in), .addr_in(file_addr_out),
		.re_in(file_re_out), .we_in(file_we_out), .wdata_in(file_wdata_out),
		.rdata_out(file_rdata_in), .is_port_out(file_is_port_in), .pin_out(file_pin_data_in));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	// a hang shows as a run far past the expected few hundred cycles
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic bwr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		bus_we_in <= 1'b1;
		bus_addr_in <= a;
		bus_wdata_in <= d;
		@(posedge ref_clk_in);
		bus_we_in <= 1'b0;
	endtask : bwr

	// read data stands only in the cycle after the strobe
	task automatic brd(input logic [3:0] a, input logic [31:0] e, input string nm);
		@(posedge ref_clk_in);
		bus_re_in <= 1'b1;
		bus_addr_in <= a;
		@(posedge ref_clk_in);
		bus_re_in <= 1'b0;
		#1 chk(nm, bus_rdata_out, e);
	endtask : brd

	// issue one op, hold it until taken, then wait for retire; lat counts cycles
	task automatic run(input baboe_pkg::baboe_op_type op, input logic [7:0] k,
		input logic [6:0] f, input logic d, input logic [2:0] b);
		@(posedge ref_clk_in);
		req_valid_in <= 1'b1;
		req_in <= '{op: op, literal: k, file_addr: f, dest_file: d, bit_idx: b};
		lat = 0;
		do begin
			@(posedge ref_clk_in);
			lat++;
		end while (req_ready_out !== 1'b1 && lat < 20);
		req_valid_in <= 1'b0;
		for (lat = 1; lat < 8; lat++) begin
			#1;
			if (done_out === 1'b1) break;
			@(posedge ref_clk_in);
		end
		chk("retire", done_out, 1'b1);
		{wev, wdv, skp, sqh} = {file_we_out, file_wdata_out, skip_out, squashed_out};
	endtask : run

	task automatic res(input logic d, input logic [7:0] r, input logic [7:0] a0,
		input logic [2:0] fl);
		chk("file_we", wev, d);
		if (d) chk("file_wdata", wdv, r);
		chk("acc", acc_out, d ? a0 : r);
		chk("flags", flags_out, fl);
	endtask : res

	task automatic t_regs();
		brd(baboe_pkg::REG_ACC_OFF, 32'h0, "acc_rst");
		brd(baboe_pkg::REG_STATUS_OFF, 32'h0, "status_rst");
		brd(baboe_pkg::REG_CTRL_OFF, 32'h1, "ctrl_rst");
		brd(4'h6, 32'h0, "unmapped");
	endtask : t_regs

	// enable off holds issue back; an idle, unarmed datapath reads state zero
	task automatic t_ctrl();
		bwr(baboe_pkg::REG_CTRL_OFF, 32'h0);
		brd(baboe_pkg::REG_CTRL_OFF, 32'h0, "ctrl_off");
		chk("ready_off", req_ready_out, 1'b0);
		brd(baboe_pkg::REG_STATE_OFF, 32'h0, "state_idle");
		bwr(baboe_pkg::REG_CTRL_OFF, 32'h1);
		brd(baboe_pkg::REG_CTRL_OFF, 32'h1, "ctrl_on");
	endtask : t_ctrl

	// carry out of bit 7 and bit 3 at once, zero result
	task automatic t_lit();
		bwr(baboe_pkg::REG_ACC_OFF, 32'h8f);
		run(baboe_pkg::add_literal_op, 8'h71, 7'h0, 1'b1, 3'h0);
		chk("lit_lat", lat, 2);
		res(1'b0, 8'h00, 8'h00, 3'b111);
		bwr(baboe_pkg::REG_ACC_OFF, 32'hf0);
		run(baboe_pkg::and_literal_op, 8'h0f, 7'h0, 1'b0, 3'h0);
		res(1'b0, 8'h00, 8'h00, 3'b111);
	endtask : t_lit

	// both destinations at both ends of the file address range
	task automatic t_file();
		logic [6:0] f;
		for (int i = 0; i < 4; i++) begin
			f = i[0] ? 7'h7f : 7'h00;
			baboe_fs_model_inst.mem[f] = 8'h06;
			bwr(baboe_pkg::REG_ACC_OFF, 32'h0a);
			bwr(baboe_pkg::REG_STATUS_OFF, 32'h0);
			run(baboe_pkg::add_file_op, 8'h0, f, i[1], 3'h0);
			chk("file_lat", lat, 3);
			res(i[1], 8'h10, 8'h0a, 3'b010);
			run(baboe_pkg::and_file_op, 8'h0, f, i[1], 3'h0);
			res(i[1], 8'h00, 8'h0a, 3'b110);
		end
	endtask : t_file

	task automatic t_bits();
		for (int b = 0; b < 8; b++) begin
			baboe_fs_model_inst.mem[7'h55] = 8'h00;
			run(baboe_pkg::bit_set_op, 8'h0, 7'h55, 1'b0, b[2:0]);
			chk("set", {wev, wdv}, {1'b1, 8'h01 << b});
			// second location, so the set's pending write cannot land on the preload
			baboe_fs_model_inst.mem[7'h56] = 8'hff;
			run(baboe_pkg::bit_clear_op, 8'h0, 7'h56, 1'b0, b[2:0]);
			chk("clr", {wev, wdv}, {1'b1, ~(8'h01 << b)});
			chk("bit_flags", flags_out, 3'b110);
		end
	endtask : t_bits

	// a true test discards the next op, a false one lets it run
	task automatic t_skip();
		bwr(baboe_pkg::REG_ACC_OFF, 32'h0);
		baboe_fs_model_inst.mem[7'h10] = 8'h08;
		run(baboe_pkg::skip_if_bit_set_op, 8'h0, 7'h10, 1'b0, 3'h3);
		chk("skip", {skp, wev}, 2'b10);
		run(baboe_pkg::add_literal_op, 8'h01, 7'h0, 1'b0, 3'h0);
		chk("nop", {lat[3:0], sqh}, {4'h1, 1'b1});
		res(1'b0, 8'h00, 8'h00, 3'b110);
		run(baboe_pkg::skip_if_bit_set_op, 8'h0, 7'h10, 1'b0, 3'h2);
		chk("noskip", skp, 1'b0);
		run(baboe_pkg::add_literal_op, 8'h01, 7'h0, 1'b0, 3'h0);
		chk("next", {lat[3:0], sqh}, {4'h2, 1'b0});
		res(1'b0, 8'h01, 8'h00, 3'b000);
	endtask : t_skip

	// clear, then a port location where pins differ from the latch
	task automatic t_clr_port();
		baboe_fs_model_inst.mem[7'h33] = 8'hff;
		run(baboe_pkg::clear_file_op, 8'h0, 7'h33, 1'b0, 3'h0);
		chk("clear", {wev, wdv}, {1'b1, 8'h00});
		chk("clear_flags", flags_out, 3'b100);
		baboe_fs_model_inst.mem[7'h20] = 8'h00;
		run(baboe_pkg::bit_clear_op, 8'h0, 7'h20, 1'b0, 3'h0);
		chk("port", wdv, 8'hfe);
	endtask : t_clr_port

	initial begin
		repeat (16) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		t_regs();
		t_ctrl();
		t_lit();
		t_file();
		t_bits();
		t_skip();
		t_clr_port();
		wrap_up();
	end
endmodule : testbench
